// ===== rtl/tpc_pkg.sv
package tpc_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [5:0] ADDR_PWM_CTRL = 6'h00;
  localparam logic [5:0] ADDR_CHOP_CFG = 6'h04;
  localparam logic [5:0] ADDR_DT_CFG   = 6'h08;
  localparam logic [5:0] ADDR_PH_ASSGN = 6'h0C;
  localparam logic [5:0] ADDR_CARRIER  = 6'h10;
  localparam logic [5:0] ADDR_CMP_U    = 6'h14;
  localparam logic [5:0] ADDR_CMP_V    = 6'h18;
  localparam logic [5:0] ADDR_CMP_W    = 6'h1C;
  localparam logic [5:0] ADDR_REPEAT   = 6'h20;
  localparam logic [5:0] ADDR_STATUS   = 6'h24;

  // ==========================================================
  // Field positions
  localparam int PCR_PSC_LSB  = 0;
  localparam int PCR_CMS_BIT  = 3;
  localparam int PCR_PMS_BIT  = 4;
  localparam int CHOP_SEL_LSB = 0;
  localparam int CHOP_FRQ_LSB = 2;
  localparam int DT_EN_BIT    = 0;
  localparam int DT_PCN_BIT   = 1;
  localparam int BYTE_OVF_BIT = 8;

  // ==========================================================
  // Reset values
  localparam logic [4:0]  PCR_RST     = 5'h00;
  localparam logic [4:0]  CHOP_RST    = 5'h00;
  localparam logic [1:0]  DT_RST      = 2'h3;
  localparam logic [5:0]  PAR_RST     = 6'h00;
  localparam logic [11:0] CARRIER_RST = 12'h00FF;
  localparam logic [12:0] CMP_RST     = 13'h0000;
  localparam logic [12:0] CMP_FULL    = 13'h1FFF;
  localparam logic [7:0]  REP_RST     = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Chopper: half periods in peripheral clocks, 16 MHz reference
  typedef logic [6:0] tpc_half_t;
  localparam tpc_half_t CHOP_HALF [8] = '{7'h50, 7'h28, 7'h14, 7'h10,
                                          7'h0A, 7'h08, 7'h06, 7'h04};

  typedef enum logic [1:0] {
    CHOP_OFF,
    CHOP_LOW,
    CHOP_HIGH,
    CHOP_BOTH
  } tpc_chop_sel_t;

endpackage

// ===== rtl/tpc_chop_if.sv
interface tpc_chop_if;
  logic [2:0] freq_sel;
  logic       wave;

  modport gen  (input freq_sel, output wave);
  modport user (output freq_sel, input wave);
endinterface

// ===== rtl/tpc_chopper.sv
module tpc_chopper (
  input  wire logic aclk,
  input  wire logic aresetn,
  tpc_chop_if.gen   cif
);
  import tpc_pkg::*;

  typedef struct packed {
    tpc_half_t cnt;
    logic      wave;
  } tpc_chop_state_t;

  tpc_chop_state_t st_q;
  tpc_chop_state_t st_d;

  // ==========================================================
  // Square wave, ~50% duty, period scales with aclk
  always_comb begin
    st_d = st_q;
    if (st_q.cnt >= CHOP_HALF[cif.freq_sel] - 7'h01) begin
      st_d.cnt  = '0;
      st_d.wave = ~st_q.wave;
    end else begin
      st_d.cnt = st_q.cnt + 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cif.wave = st_q.wave;

endmodule

// ===== rtl/tpc_pwm_top.sv
// Functional notes
// - Two-bit chopper select: off, low channels, high channels, or both.
// - Three-bit frequency select picks one of eight chopper carriers.
// - Single-signal, no deadtime: phase assignment decides high or low channels.
// - Single-signal with deadtime: fixed pairs, even high, odd low.
// - Three independent phase signals share one carrier period.
// - Three-signal bit clear routes only phase U; set routes all three.
// - Free-running 12-bit counter and three 13-bit phase compares.
// - 12-bit carrier compare sets the counter top.
// - Compares load from preload copies only at update events.
// - Prescaler divides the clock by 1 to 8.
// - New prescaler value applies only after the next update event.
// - Alignment bit one selects center-aligned, zero edge-aligned.
// - Center mode counts up to carrier, down to zero, repeats.
// - Center mode: low at up-count match, high at down-count match.
// - Edge mode counts up to carrier, then clears to zero.
// - Edge mode: low at up-count match, high when counter clears.
// - Compare above carrier holds one; compare zero holds zero.
// - Counter zero-extended to 13 bits against 13-bit compares.
// - Byte mode gives full 8-bit range with single compare write.
// - Transfer happens only when repetition down-counter has reached zero.
module tpc_pwm_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [5:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [5:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [5:0]       motor_out,
  output logic             input_stage_pwm,
  output logic             update_event
);
  import tpc_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic             aw_rdy;
    logic             aw_hold;
    logic [5:0]       aw_addr;
    logic             w_rdy;
    logic             w_hold;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             ar_rdy;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [4:0]       pcr_pre;
    logic [4:0]       pcr_act;
    logic [4:0]       chop;
    logic [1:0]       dtc;
    logic [5:0]       par;
    logic [11:0]      car_pre;
    logic [11:0]      car_act;
    logic [2:0][12:0] cmp_pre;
    logic [2:0][12:0] cmp_act;
    logic [7:0]       rep_pre;
    logic [7:0]       rep_cnt;
    logic [2:0]       psc_cnt;
    logic [11:0]      cnt;
    logic             down;
    logic [2:0]       ph;
    logic [5:0]       mout;
    logic             in_u;
    logic             upd;
  } tpc_state_t;

  tpc_state_t st_q;
  tpc_state_t st_d;

  logic [2:0] ph_nx;
  logic [5:0] mout_nx;

  tpc_chop_if chop_if ();

  assign chop_if.freq_sel = st_q.chop[CHOP_FRQ_LSB +: 3];

  tpc_chopper u_chopper (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cif     (chop_if)
  );

  // ==========================================================
  // Register read view (preload copies read back)
  function automatic logic [32:0] reg_read(
    input logic [5:0] addr,
    input tpc_state_t s
  );
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    unique case (addr)
      ADDR_PWM_CTRL: r[4:0] = s.pcr_pre;
      ADDR_CHOP_CFG: r[4:0] = s.chop;
      ADDR_DT_CFG:   r[1:0] = s.dtc;
      ADDR_PH_ASSGN: r[5:0] = s.par;
      ADDR_CARRIER:  r[11:0] = s.car_pre;
      ADDR_CMP_U:    r[12:0] = s.cmp_pre[0];
      ADDR_CMP_V:    r[12:0] = s.cmp_pre[1];
      ADDR_CMP_W:    r[12:0] = s.cmp_pre[2];
      ADDR_REPEAT:   r[7:0] = s.rep_pre;
      ADDR_STATUS:   r[12:0] = {s.down, s.cnt};
      default:       r[32] = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] wmerge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Byte mode: low byte is the compare, bit 8 forces full duty
  function automatic logic [12:0] cmp_val(
    input logic [31:0] v,
    input logic        byte_mode
  );
    logic [12:0] r;
    r = v[12:0];
    if (byte_mode) begin
      r = v[BYTE_OVF_BIT] ? CMP_FULL : {5'h00, v[7:0]};
    end
    return r;
  endfunction

  // ==========================================================
  // Phase compare, one per phase
  for (genvar i = 0; i < 3; i++) begin : g_phase
    logic [12:0] ext;
    assign ext = {1'b0, st_q.cnt};
    // Compare above carrier never matches, so the level holds
    assign ph_nx[i] = st_q.down ? (ext <= st_q.cmp_act[i])
                                : (ext < st_q.cmp_act[i]);
  end

  // ==========================================================
  // Channel routing and chopping, one per output
  for (genvar c = 0; c < 6; c++) begin : g_chan
    logic paired;
    logic src;
    logic base;
    logic high;
    logic chop_on;
    assign paired = st_q.dtc[DT_PCN_BIT] | st_q.dtc[DT_EN_BIT];
    assign src    = st_q.dtc[DT_PCN_BIT] ? st_q.ph[c/2] : st_q.ph[0];
    // Low member is the complement; deadtime is added downstream
    assign base   = (paired && (c % 2 == 1)) ? ~src : src;
    assign high   = paired ? (c % 2 == 0) : st_q.par[c];
    assign chop_on = high ? st_q.chop[CHOP_SEL_LSB + 1]
                          : st_q.chop[CHOP_SEL_LSB];
    assign mout_nx[c] = chop_on ? (base & chop_if.wave) : base;
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic        do_wr;
    logic [32:0] rd;
    logic [31:0] nv;
    logic        tick;
    logic        evt;
    logic        bm;
    do_wr = 1'b0;
    rd    = '0;
    nv    = '0;
    tick  = 1'b0;
    evt   = 1'b0;
    bm    = st_q.pcr_act[PCR_PMS_BIT];
    st_d  = st_q;

    // Write channel: address and data taken in either order
    if (awvalid && st_q.aw_rdy) begin
      st_d.aw_hold = 1'b1;
      st_d.aw_addr = awaddr;
    end
    if (wvalid && st_q.w_rdy) begin
      st_d.w_hold = 1'b1;
      st_d.w_data = wdata;
      st_d.w_strb = wstrb;
    end
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
    end
    do_wr = st_q.aw_hold && st_q.w_hold && !st_q.bvalid;
    if (do_wr) begin
      rd = reg_read(st_q.aw_addr, st_q);
      nv = wmerge(rd[31:0], st_q.w_data, st_q.w_strb);
      st_d.aw_hold = 1'b0;
      st_d.w_hold  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = rd[32] ? RESP_OKAY : RESP_SLVERR;
      unique case (st_q.aw_addr)
        ADDR_PWM_CTRL: st_d.pcr_pre = nv[4:0];
        ADDR_CHOP_CFG: st_d.chop = nv[4:0];
        ADDR_DT_CFG:   st_d.dtc = nv[1:0];
        ADDR_PH_ASSGN: st_d.par = nv[5:0];
        ADDR_CARRIER:  begin
          st_d.car_pre = bm ? {4'h0, nv[7:0]} : nv[11:0];
        end
        ADDR_CMP_U:    st_d.cmp_pre[0] = cmp_val(nv, bm);
        ADDR_CMP_V:    st_d.cmp_pre[1] = cmp_val(nv, bm);
        ADDR_CMP_W:    st_d.cmp_pre[2] = cmp_val(nv, bm);
        ADDR_REPEAT:   st_d.rep_pre = nv[7:0];
        default:       st_d.bresp = RESP_SLVERR;
      endcase
    end
    st_d.aw_rdy = !st_d.aw_hold;
    st_d.w_rdy  = !st_d.w_hold;

    // Read channel
    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
    end
    if (arvalid && st_q.ar_rdy) begin
      rd = reg_read(araddr, st_q);
      st_d.rvalid = 1'b1;
      st_d.rdata  = rd[31:0];
      st_d.rresp  = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end
    st_d.ar_rdy = !st_d.rvalid;

    // Prescaler
    tick = (st_q.psc_cnt >= st_q.pcr_act[PCR_PSC_LSB +: 3]);
    st_d.psc_cnt = tick ? 3'h0 : st_q.psc_cnt + 3'h1;

    // Counter
    if (tick) begin
      if (!st_q.pcr_act[PCR_CMS_BIT]) begin
        st_d.down = 1'b0;
        if (st_q.cnt >= st_q.car_act) begin
          st_d.cnt = 12'h000;
          evt = 1'b1;
        end else begin
          st_d.cnt = st_q.cnt + 12'h001;
        end
      end else if (!st_q.down) begin
        if (st_q.cnt >= st_q.car_act) begin
          st_d.down = 1'b1;
          st_d.cnt  = st_q.cnt - 12'h001;
          evt = 1'b1;
        end else begin
          st_d.cnt = st_q.cnt + 12'h001;
        end
      end else begin
        if (st_q.cnt <= 12'h001) begin
          st_d.down = 1'b0;
          st_d.cnt  = 12'h000;
          evt = 1'b1;
        end else begin
          st_d.cnt = st_q.cnt - 12'h001;
        end
      end
    end

    // Update event with repetition
    st_d.upd = 1'b0;
    if (evt) begin
      if (st_q.rep_cnt == 8'h00) begin
        st_d.rep_cnt = st_q.rep_pre;
        st_d.car_act = st_q.car_pre;
        st_d.cmp_act = st_q.cmp_pre;
        st_d.pcr_act = st_q.pcr_pre;
        st_d.upd     = 1'b1;
      end else begin
        st_d.rep_cnt = st_q.rep_cnt - 8'h01;
      end
    end

    // Outputs
    st_d.ph   = ph_nx;
    st_d.mout = mout_nx;
    st_d.in_u = st_q.ph[0];
  end

  // ==========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q         <= '0;
      st_q.aw_rdy  <= 1'b1;
      st_q.w_rdy   <= 1'b1;
      st_q.ar_rdy  <= 1'b1;
      st_q.pcr_pre <= PCR_RST;
      st_q.pcr_act <= PCR_RST;
      st_q.chop    <= CHOP_RST;
      st_q.dtc     <= DT_RST;
      st_q.par     <= PAR_RST;
      st_q.car_pre <= CARRIER_RST;
      st_q.car_act <= CARRIER_RST;
      st_q.cmp_pre <= {3{CMP_RST}};
      st_q.cmp_act <= {3{CMP_RST}};
      st_q.rep_pre <= REP_RST;
      st_q.rep_cnt <= REP_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Port drive
  assign awready         = st_q.aw_rdy;
  assign wready          = st_q.w_rdy;
  assign bvalid          = st_q.bvalid;
  assign bresp           = st_q.bresp;
  assign arready         = st_q.ar_rdy;
  assign rvalid          = st_q.rvalid;
  assign rdata           = st_q.rdata;
  assign rresp           = st_q.rresp;
  assign motor_out       = st_q.mout;
  assign input_stage_pwm = st_q.in_u;
  assign update_event    = st_q.upd;

endmodule

// ===== sim/tpc_pwm_properties.sv
module tpc_pwm_properties (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic [1:0] bresp,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       rready,
  input wire logic [5:0] motor_out,
  input wire logic       update_event
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Bus and output timing
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rst_quiet_a: assert property (disable iff (1'b0)
    !aresetn |=> motor_out == 6'h00 && !bvalid && !rvalid && !update_event)
    else $error("outputs not cleared by reset");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  // Both halves are registered first, the answer follows one edge later
  b_after_a: assert property (awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
    else $error("write answer late");
  b_free_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channel not freed");
  r_after_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  r_hold_a: assert property (rvalid && !rready |=> rvalid)
    else $error("read answer dropped early");
  ar_refuse_a: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  upd_pulse_a: assert property (update_event |=> !update_event)
    else $error("update pulse too long");
endmodule

bind tpc_pwm_top tpc_pwm_properties u_props (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .motor_out(motor_out),
  .update_event(update_event));

// ===== sim/tpc_drive_model.sv
module tpc_drive_model (
  input  wire logic        aclk,
  input  wire logic        clr,
  input  wire logic [5:0]  motor_out,
  output logic      [15:0] hi_cnt [6]
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Gate drivers: on-time per switch, phase independent
  always @(posedge aclk) begin
    for (int i = 0; i < 6; i++) begin
      hi_cnt[i] <= clr ? 16'h0000 : hi_cnt[i] + 16'(motor_out[i]);
    end
  end
endmodule

// ===== sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tpc_pkg::*;
  logic        aclk = 0, aresetn = 0, clr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [5:0]  awaddr = 0, araddr = 0, motor_out;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, input_stage_pwm, update_event;
  logic [15:0] hi_cnt [6];
  logic [15:0] in_cnt, upd_cnt;
  int          error_cnt = 0, checks_done = 0;

  tpc_pwm_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .motor_out(motor_out), .input_stage_pwm(input_stage_pwm), .update_event(update_event));
  tpc_drive_model drv (.aclk(aclk), .clr(clr), .motor_out(motor_out), .hi_cnt(hi_cnt));

  always #50 aclk = ~aclk;

  // Input stage level and update pulses, counted over the same window
  always @(posedge aclk) begin
    in_cnt  <= clr ? 16'h0000 : in_cnt + 16'(input_stage_pwm);
    upd_cnt <= clr ? 16'h0000 : upd_cnt + 16'(update_event);
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [12:0] d, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {19'h0_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      awvalid <= awvalid && !awready;
      wvalid <= wvalid && !wready;
      n++;
    end while (!bvalid && n < 1000);
    chk({15'h0000, bvalid}, 16'h0001, "bvalid");
    chk({14'h0000, bresp}, {14'h0000, er}, "bresp");
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [12:0] e, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      arvalid <= arvalid && !arready;
      n++;
    end while (!rvalid && n < 1000);
    chk({15'h0000, rvalid}, 16'h0001, "rvalid");
    chk(rdata[15:0], {3'h0, e}, "rdata");
    chk({14'h0000, rresp}, {14'h0000, er}, "rresp");
    rready <= 1'b0;
  endtask

  // Two events, so the transfer surely postdates the last write
  task automatic sync();
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (update_event !== 1'b1 && n < 3000);
      chk({15'h0000, update_event}, 16'h0001, "update event");
    end
    repeat (4) @(posedge aclk);
  endtask

  task automatic win(input int len);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (len) @(posedge aclk);
    #1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(ADDR_PWM_CTRL, 13'h0000);
    rd(ADDR_DT_CFG, 13'h0003);
    rd(ADDR_CARRIER, 13'h00FF);
    rd(6'h28, 13'h0000, RESP_SLVERR);
    wr(6'h2C, 13'h0001, RESP_SLVERR);
  endtask

  task automatic t_edge();
    logic [12:0] cv [4] = '{13'h0003, 13'h0000, 13'h0009, 13'h000A};
    logic [15:0] ev [4] = '{16'h0006, 16'h0000, 16'h0012, 16'h0014};
    wr(ADDR_CARRIER, 13'h0009);
    wr(ADDR_CMP_V, 13'h0007);
    wr(ADDR_CMP_W, 13'h000A);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CMP_U, cv[i]);
      rd(ADDR_CMP_U, cv[i]);
      sync();
      win(20);
      chk(hi_cnt[0], ev[i], "edge duty");
    end
    chk(hi_cnt[1], 16'h0000, "low member");
    chk(hi_cnt[2], 16'h000E, "phase v");
    chk(hi_cnt[4], 16'h0014, "phase w full");
  endtask

  task automatic t_route();
    wr(ADDR_CMP_U, 13'h0003);
    wr(ADDR_DT_CFG, 13'h0001);
    sync();
    win(20);
    chk(hi_cnt[2], 16'h0006, "u on pair 1");
    chk(hi_cnt[5], 16'h000E, "u low pair 2");
    chk(in_cnt, 16'h0006, "input stage");
    wr(ADDR_REPEAT, 13'h0001);
    sync();
    win(40);
    chk(upd_cnt, 16'h0002, "repeat rate");
    wr(ADDR_REPEAT, 13'h0000);
    wr(ADDR_DT_CFG, 13'h0003);
  endtask

  task automatic t_mode();
    wr(ADDR_PWM_CTRL, 13'h0001);
    sync();
    win(40);
    chk(hi_cnt[0], 16'h000C, "prescale 2");
    wr(ADDR_PWM_CTRL, 13'h0008);
    sync();
    win(18);
    chk(hi_cnt[0], 16'h0006, "center duty");
    wr(ADDR_PWM_CTRL, 13'h0010);
    sync();
    wr(ADDR_CMP_U, 13'h0100);
    sync();
    win(20);
    chk(hi_cnt[0], 16'h0014, "byte full");
    wr(ADDR_PWM_CTRL, 13'h0000);
    sync();
  endtask

  task automatic t_chop();
    wr(ADDR_CMP_U, 13'h000A);
    wr(ADDR_CMP_V, 13'h0000);
    sync();
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CHOP_CFG, 13'(5'h1C | s));
      repeat (12) @(posedge aclk);
      win(16);
      chk(hi_cnt[0], s[1] ? 16'h0008 : 16'h0010, "chop high");
      chk(hi_cnt[3], s[0] ? 16'h0008 : 16'h0010, "chop low");
    end
    for (int f = 0; f < 8; f++) begin
      wr(ADDR_CHOP_CFG, 13'({f[2:0], 2'h2}));
      repeat (2 * CHOP_HALF[f] + 4) @(posedge aclk);
      win(2 * CHOP_HALF[f]);
      chk(hi_cnt[0], 16'(CHOP_HALF[f]), "chop rate");
    end
    // Single signal, no deadtime: channel 0 assigned high, channel 1 low
    wr(ADDR_DT_CFG, 13'h0000);
    wr(ADDR_PH_ASSGN, 13'h0001);
    wr(ADDR_CHOP_CFG, 13'h001E);
    repeat (12) @(posedge aclk);
    win(16);
    chk(hi_cnt[0], 16'h0008, "assigned high");
    chk(hi_cnt[1], 16'h0010, "assigned low");
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #8_000_000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_edge();
    t_route();
    t_mode();
    t_chop();
    end_of_test();
  end
endmodule
